/* hw/fspc_defines.svh */
// constants for the flash self-program controller
// Function
// - rows of 32 words, 14 bits each
// - erase sets ones, program clears to zero
// - 32 hidden latches filled by data writes
// - whole or partial row programming allowed
// - code protect blocks external, not self access
// - only external bulk erase clears code protect; reset also clears codeProtected here
// - write-protect field blocks self write and erase
// - firmware gets row writes and row erases only
// - indirect read: one cycle, stall, one byte
// - indirect path is read-only
// - config and ids read-only, user ids writable
// - protected region write or erase suppressed
// - read stalls cpu, data next cycle
// - data pair holds until read or overwrite
// - read trigger self-clears on completion
// - modify operations only after unlock
// - unlock steps back to back or refused
// - cpu stalls until operation ends
// - internal timer times write and erase
// - protected target clears trigger, skips erase
// - erase done sets flag, irq if enabled
`ifndef FSPC_DEFINES_SVH
`define FSPC_DEFINES_SVH
`define FSPC_ROW_WORDS 32
`define FSPC_WORD_W 14
`define FSPC_ADDR_W 15
`define FSPC_PFM_WORDS 2048
`define FSPC_ID_WORDS 16
`define FSPC_KEY1 8'h55
`define FSPC_KEY2 8'haa
`define FSPC_ERASED 14'h3fff
`define FSPC_CFG_FIRST 15'h0005
`define FSPC_USERID_LAST 15'h0003
`define FSPC_WRITE_NS 2000
`define FSPC_WRITE_CYC ((`FSPC_WRITE_NS * 200 + 999) / 1000)
`endif

/* hw/fspc_pkg.sv */
// types for the flash self-program controller
package fspc_pkg;
	typedef enum logic [2:0] {
		FSPC_IDLE = 3'b000,
		FSPC_KEY1 = 3'b001,
		FSPC_KEY2 = 3'b011,
		FSPC_BUSY = 3'b010
	} fspc_state_t;
	typedef logic [13:0] fspc_word_t;
endpackage : fspc_pkg

/* hw/fspc_flash_self_program_ctrl.sv */
// flash self-program controller with array, latches and unlock logic
`timescale 1ns/1ps
`include "fspc_defines.svh"
module fspc_flash_self_program_ctrl #(
	parameter int WRITE_CYC = `FSPC_WRITE_CYC
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	// register port writes from the cpu
	input wire logic keyWrite,
	input wire logic [7:0] keyData,
	input wire logic addrLowWrite,
	input wire logic addrHighWrite,
	input wire logic [7:0] cpuWrData,
	input wire logic dataLowWrite,
	input wire logic dataHighWrite,
	input wire logic ctrlWrite,
	input wire logic setReadTrig,
	input wire logic setProgTrig,
	input wire logic configSpaceSelectIn,
	input wire logic eraseSelectIn,
	input wire logic modifyEnableIn,
	input wire logic doneIrqEnable,
	input wire logic clearDoneFlag,
	// indirect pointer read path
	input wire logic indirectRead,
	input wire logic indirectWrite,
	input wire logic [15:0] indirectPointer,
	// protection configuration
	input wire logic [1:0] selfUpdateGuard,
	input wire logic codeProtectBit_n,
	input wire logic extBulkErase,
	// register port readback
	output logic [14:0] flashAddress,
	output fspc_pkg::fspc_word_t flashData,
	output logic configSpaceSelect,
	output logic eraseSelect,
	output logic modifyEnable,
	output logic readTrig,
	output logic progTrig,
	output logic flashDoneFlag,
	output logic flashDoneIrq,
	output logic [7:0] indirectData,
	output logic cpuStall,
	output logic codeProtected
);
	import fspc_pkg::*;

	// ------------------------------
	// storage
	// ------------------------------
	// row organised array
	fspc_word_t program_flash_array [`FSPC_PFM_WORDS];
	fspc_word_t idSpace [`FSPC_ID_WORDS];
	fspc_word_t latch [`FSPC_ROW_WORDS];
	fspc_state_t state_q;
	logic [15:0] timer_q;
	logic opErase_q;
	logic opIdle;
	logic keyBad;
	logic protHit;
	logic opStart;
	logic [10:0] pfmAddr;
	logic [4:0] col;
	logic [3:0] idAddr;

	assign pfmAddr = flashAddress[10:0];
	assign col = flashAddress[4:0];
	assign idAddr = flashAddress[3:0];
	assign opIdle = (state_q != FSPC_BUSY);
	// key write in the trigger cycle breaks the sequence
	assign opStart = (state_q == FSPC_KEY2) && setProgTrig && modifyEnable && !protHit && !keyWrite;

	// ------------------------------
	// protection decode
	// ------------------------------
	// guard field regions
	always_comb begin
		protHit = 1'b0;
		if (configSpaceSelect) begin
			protHit = (flashAddress > `FSPC_USERID_LAST);
		end else begin
			unique case (selfUpdateGuard)
				2'b11: protHit = 1'b0;
				2'b10: protHit = (pfmAddr < 11'h200);
				2'b01: protHit = (pfmAddr < 11'h400);
				2'b00: protHit = 1'b1;
			endcase
		end
	end

	// ------------------------------
	// control bits
	// ------------------------------
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			configSpaceSelect <= 1'b0;
			eraseSelect <= 1'b0;
			modifyEnable <= 1'b0;
		end else if (ctrlWrite && opIdle) begin
			configSpaceSelect <= configSpaceSelectIn;
			eraseSelect <= eraseSelectIn;
			modifyEnable <= modifyEnableIn;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			flashAddress <= 15'h0000;
		end else if (opIdle) begin
			if (addrLowWrite)
				flashAddress[7:0] <= cpuWrData;
			if (addrHighWrite)
				flashAddress[14:8] <= cpuWrData[6:0];
		end
	end

	// ------------------------------
	// unlock sequencer
	// ------------------------------
	// wrong key restarts
	assign keyBad = keyWrite && !((state_q == FSPC_IDLE && keyData == `FSPC_KEY1) ||
		(state_q == FSPC_KEY1 && keyData == `FSPC_KEY2));

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= FSPC_IDLE;
		end else begin
			unique case (state_q)
				FSPC_IDLE: if (keyWrite && keyData == `FSPC_KEY1) state_q <= FSPC_KEY1;
				FSPC_KEY1: if (keyWrite && keyData == `FSPC_KEY2) state_q <= FSPC_KEY2;
					else state_q <= FSPC_IDLE;
				FSPC_KEY2: if (opStart) state_q <= FSPC_BUSY;
					else state_q <= FSPC_IDLE;
				FSPC_BUSY: if (timer_q == 16'h0001) state_q <= FSPC_IDLE;
				default: state_q <= FSPC_IDLE;
			endcase
			if (keyBad && state_q != FSPC_BUSY)
				state_q <= FSPC_IDLE;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			timer_q <= 16'h0000;
			opErase_q <= 1'b0;
		end else if (opStart) begin
			timer_q <= WRITE_CYC[15:0];
			opErase_q <= eraseSelect;
		end else if (timer_q != 16'h0000) begin
			timer_q <= timer_q - 16'h0001;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			progTrig <= 1'b0;
			cpuStall <= 1'b0;
		end else begin
			progTrig <= opStart || (state_q == FSPC_BUSY && timer_q != 16'h0001);
			cpuStall <= opStart || (state_q == FSPC_BUSY && timer_q != 16'h0001) ||
				(setReadTrig && opIdle) || indirectRead;
		end
	end

	// ------------------------------
	// array update
	// ------------------------------
	// no firmware bulk erase
	always_ff @(posedge clk_sys) begin
		if (extBulkErase) begin
			for (int i = 0; i < `FSPC_PFM_WORDS; i++)
				program_flash_array[i] <= `FSPC_ERASED;
			for (int i = 0; i < `FSPC_ID_WORDS; i++)
				idSpace[i] <= `FSPC_ERASED;
		end else if (state_q == FSPC_BUSY && timer_q == 16'h0001) begin
			for (int i = 0; i < `FSPC_ROW_WORDS; i++) begin
				if (configSpaceSelect) begin
					if (i < `FSPC_ID_WORDS && (i[4:0] & 5'h1c) == (col & 5'h1c) && i < 4) begin
						// erase to ones, program to zeros
						if (opErase_q)
							idSpace[i] <= `FSPC_ERASED;
						else
							idSpace[i] <= idSpace[i] & latch[i];
					end
				end else if (opErase_q) begin
					program_flash_array[{pfmAddr[10:5], i[4:0]}] <= `FSPC_ERASED;
				end else begin
					program_flash_array[{pfmAddr[10:5], i[4:0]}] <= program_flash_array[{pfmAddr[10:5], i[4:0]}] & latch[i];
				end
			end
		end
	end

	// latches load through the data pair; cleared to ones after a program
	always_ff @(posedge clk_sys) begin
		if (!arst_n) begin
			for (int i = 0; i < `FSPC_ROW_WORDS; i++)
				latch[i] <= `FSPC_ERASED;
		end else if (dataHighWrite && opIdle && modifyEnable) begin
			latch[col] <= {cpuWrData[5:0], flashData[7:0]};
		end else if (state_q == FSPC_BUSY && timer_q == 16'h0001 && !opErase_q) begin
			for (int i = 0; i < `FSPC_ROW_WORDS; i++)
				latch[i] <= `FSPC_ERASED;
		end
	end

	// ------------------------------
	// reads and completion
	// ------------------------------
	// data pair holds
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			flashData <= 14'h0000;
			readTrig <= 1'b0;
		end else begin
			// trigger shows for the single read cycle only
			readTrig <= setReadTrig && opIdle;
			if (setReadTrig && opIdle) begin
				if (configSpaceSelect)
					flashData <= idSpace[idAddr];
				else
					flashData <= program_flash_array[pfmAddr];
			end else if (opIdle) begin
				if (dataLowWrite)
					flashData[7:0] <= cpuWrData;
				if (dataHighWrite)
					flashData[13:8] <= cpuWrData[5:0];
			end
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			indirectData <= 8'h00;
		else if (indirectRead && !indirectWrite)
			indirectData <= program_flash_array[indirectPointer[10:0]][7:0];
	end

	// done flag, set wins over clear
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			flashDoneFlag <= 1'b0;
			flashDoneIrq <= 1'b0;
		end else begin
			if (state_q == FSPC_BUSY && timer_q == 16'h0001)
				flashDoneFlag <= 1'b1;
			else if (clearDoneFlag)
				flashDoneFlag <= 1'b0;
			flashDoneIrq <= flashDoneFlag && doneIrqEnable;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			codeProtected <= 1'b0;
		else if (extBulkErase)
			codeProtected <= 1'b0;
		// sticky: releasing the pin alone never unprotects
		else if (!codeProtectBit_n)
			codeProtected <= 1'b1;
	end

	// ------------------------------
	// checks
	// ------------------------------
	property p_readNext;
		@(posedge clk_sys) disable iff (!arst_n) (setReadTrig && opIdle) |=> cpuStall && readTrig;
	endproperty
	a_readNext: assert property (p_readNext) else $error("read did not stall");

	property p_keyOrder;
		@(posedge clk_sys) disable iff (!arst_n) (state_q == FSPC_KEY2) |-> $past(state_q) == FSPC_KEY1;
	endproperty
	a_keyOrder: assert property (p_keyOrder) else $error("unlock out of order");

	property p_noEnable;
		@(posedge clk_sys) disable iff (!arst_n) (setProgTrig && !modifyEnable) |=> state_q != FSPC_BUSY;
	endproperty
	a_noEnable: assert property (p_noEnable) else $error("trigger without enable");

	property p_protSkip;
		@(posedge clk_sys) disable iff (!arst_n) (state_q == FSPC_KEY2 && protHit) |=> !progTrig;
	endproperty
	a_protSkip: assert property (p_protSkip) else $error("protected op ran");

	property p_stallBusy;
		@(posedge clk_sys) disable iff (!arst_n) (state_q == FSPC_BUSY && timer_q > 16'h0001) |=> cpuStall;
	endproperty
	a_stallBusy: assert property (p_stallBusy) else $error("cpu not stalled");

	property p_done;
		@(posedge clk_sys) disable iff (!arst_n) (state_q == FSPC_BUSY && timer_q == 16'h0001) |=> flashDoneFlag;
	endproperty
	a_done: assert property (p_done) else $error("done flag missing");

	property p_unlock;
		@(posedge clk_sys) disable iff (!arst_n) $rose(progTrig) |-> $past(state_q) == FSPC_KEY2;
	endproperty
	a_unlock: assert property (p_unlock) else $error("op without unlock");

	property p_rdClear;
		@(posedge clk_sys) disable iff (!arst_n) readTrig |=> !readTrig;
	endproperty
	a_rdClear: assert property (p_rdClear) else $error("read trigger stuck");

	property p_indStall;
		@(posedge clk_sys) disable iff (!arst_n) indirectRead |=> cpuStall;
	endproperty
	a_indStall: assert property (p_indStall) else $error("indirect read did not stall");

	property p_indReadOnly;
		@(posedge clk_sys) disable iff (!arst_n) (indirectWrite && !indirectRead) |=> $stable(indirectData);
	endproperty
	a_indReadOnly: assert property (p_indReadOnly) else $error("indirect write had effect");

	property p_dataHold;
		@(posedge clk_sys) disable iff (!arst_n)
			(!(setReadTrig && opIdle) && !dataLowWrite && !dataHighWrite) |=> $stable(flashData);
	endproperty
	a_dataHold: assert property (p_dataHold) else $error("data pair changed");

	property p_busyEnd;
		@(posedge clk_sys) disable iff (!arst_n) (state_q == FSPC_BUSY && timer_q == 16'h0001) |=> !progTrig && opIdle;
	endproperty
	a_busyEnd: assert property (p_busyEnd) else $error("operation did not end");

	property p_bulkClear;
		@(posedge clk_sys) disable iff (!arst_n) extBulkErase |=> !codeProtected;
	endproperty
	a_bulkClear: assert property (p_bulkClear) else $error("protection kept after bulk erase");
endmodule : fspc_flash_self_program_ctrl

/* testbench/fspc_cpu_model.sv */
// cpu-side model that runs the unlock sequence
`timescale 1ns/1ps
module fspc_cpu_model (
	// clock and stall
	input wire logic clk_sys,
	input wire logic cpuStall,
	// key port
	output logic keyWrite,
	output logic [7:0] keyData,
	output logic setProgTrig
);
	// ----------------------------
	// unlock sequencer
	// ----------------------------
	initial begin
		keyWrite = 1'b0;
		keyData = 8'h00;
		setProgTrig = 1'b0;
	end
	task automatic unlock(input logic [7:0] key2, output int n);
		@(posedge clk_sys);
		keyWrite <= 1'b1;
		keyData <= 8'h55;
		@(posedge clk_sys);
		keyData <= key2;
		@(posedge clk_sys);
		keyWrite <= 1'b0;
		// released bus shows inverse, not last value
		keyData <= ~key2;
		setProgTrig <= 1'b1;
		@(posedge clk_sys);
		setProgTrig <= 1'b0;
		n = 0;
		for (int i = 0; i < 12; i++) begin
			#1;
			if (cpuStall === 1'b1) n++;
			@(posedge clk_sys);
		end
	endtask : unlock
endmodule : fspc_cpu_model

/* testbench/tb.sv */
// self-checking bench for the flash self-program controller
`timescale 1ns/1ps
module tb;
	import fspc_pkg::*;
	localparam int W = 4;
	logic clk_sys, arst_n, keyWrite, setProgTrig, irqEn;
	logic [8:0] strb;
	logic [7:0] wd, keyData, indirectData;
	logic [15:0] ptr;
	logic [1:0] guard;
	logic [14:0] flashAddress;
	fspc_word_t flashData;
	logic cfgSel, eraseSel, modEn, readTrig, progTrig, doneFlag, doneIrq, cpuStall, codeProt;
	logic cpBitN, bulk;
	int fails = 0;
	int comparisons = 0;
	int n;
	fspc_flash_self_program_ctrl #(.WRITE_CYC(W)) uut (
		.clk_sys(clk_sys), .arst_n(arst_n), .keyWrite(keyWrite), .keyData(keyData),
		.addrLowWrite(strb[0]), .addrHighWrite(strb[1]), .cpuWrData(wd),
		.dataLowWrite(strb[2]), .dataHighWrite(strb[3]), .ctrlWrite(strb[4]),
		.setReadTrig(strb[5]), .setProgTrig(setProgTrig), .configSpaceSelectIn(wd[2]),
		.eraseSelectIn(wd[1]), .modifyEnableIn(wd[0]), .doneIrqEnable(irqEn),
		.clearDoneFlag(strb[6]), .indirectRead(strb[7]), .indirectWrite(strb[8]),
		.indirectPointer(ptr), .selfUpdateGuard(guard), .codeProtectBit_n(cpBitN),
		.extBulkErase(bulk), .flashAddress(flashAddress), .flashData(flashData),
		.configSpaceSelect(cfgSel), .eraseSelect(eraseSel), .modifyEnable(modEn),
		.readTrig(readTrig), .progTrig(progTrig), .flashDoneFlag(doneFlag),
		.flashDoneIrq(doneIrq), .indirectData(indirectData), .cpuStall(cpuStall),
		.codeProtected(codeProt)
	);
	fspc_cpu_model cpu (
		.clk_sys(clk_sys), .cpuStall(cpuStall), .keyWrite(keyWrite),
		.keyData(keyData), .setProgTrig(setProgTrig)
	);
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	// ----------------------------
	// access tasks
	// ----------------------------
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask : check
	task automatic op(input int b, input logic [7:0] d);
		@(posedge clk_sys);
		strb <= 9'h001 << b;
		wd <= d;
		@(posedge clk_sys);
		strb <= 9'h000;
	endtask : op
	task automatic rd(input logic [14:0] a);
		op(0, a[7:0]);
		op(1, {1'b0, a[14:8]});
		op(5, 8'h00);
		#1;
		check("read stall", 16'h0001, 16'(cpuStall));
		check("read trigger set", 16'h0001, 16'(readTrig));
		@(posedge clk_sys);
		#1;
		check("read trigger cleared", 16'h0000, 16'(readTrig));
	endtask : rd
	task automatic stop_test();
		$display("comparisons %0d, fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : stop_test
	// tests need well under 400 cycles; 2000 leaves margin
	initial begin
		#10000;
		fails++;
		stop_test();
	end
	// ----------------------------
	// tests
	// ----------------------------
	initial begin
		arst_n = 1'b0;
		strb = 9'h000;
		wd = 8'h00;
		ptr = 16'h0000;
		guard = 2'b11;
		irqEn = 1'b0;
		cpBitN = 1'b0;
		bulk = 1'b0;
		repeat (6) @(posedge clk_sys);
		arst_n <= 1'b1;
		#1;
		check("progTrig at reset", 16'h0000, 16'(progTrig));
		op(0, 8'h25);
		op(1, 8'h00);
		op(4, 8'h03);
		cpu.unlock(8'haa, n);
		check("erase stall", 16'(W), 16'(n));
		check("code protect set", 16'h0001, 16'(codeProt));
		check("erase done flag", 16'h0001, 16'(doneFlag));
		rd(15'h0025);
		check("erased word", 16'h3fff, 16'(flashData));
		op(6, 8'h00);
		#1;
		check("flag cleared", 16'h0000, 16'(doneFlag));
		$display("test erase done");
		op(4, 8'h01);
		op(0, 8'h25);
		op(2, 8'h34);
		op(3, 8'h12);
		cpu.unlock(8'haa, n);
		check("program stall", 16'(W), 16'(n));
		rd(15'h0025);
		check("programmed word", 16'h1234, 16'(flashData));
		rd(15'h0024);
		check("untouched word", 16'h3fff, 16'(flashData));
		check("done flag", 16'h0001, 16'(doneFlag));
		check("irq while disabled", 16'h0000, 16'(doneIrq));
		@(posedge clk_sys);
		irqEn <= 1'b1;
		repeat (2) @(posedge clk_sys);
		#1;
		check("done irq", 16'h0001, 16'(doneIrq));
		op(6, 8'h00);
		#1;
		check("cleared flag", 16'h0000, 16'(doneFlag));
		check("code protect held", 16'h0001, 16'(codeProt));
		$display("test program done");
		cpu.unlock(8'h55, n);
		check("wrong key stall", 16'h0000, 16'(n));
		op(4, 8'h00);
		cpu.unlock(8'haa, n);
		check("no enable stall", 16'h0000, 16'(n));
		@(posedge clk_sys);
		guard <= 2'b00;
		op(4, 8'h03);
		op(0, 8'h25);
		cpu.unlock(8'haa, n);
		check("guarded stall", 16'h0000, 16'(n));
		check("guarded trigger", 16'h0000, 16'(progTrig));
		rd(15'h0025);
		check("guarded word", 16'h1234, 16'(flashData));
		check("flag after refusals", 16'h0000, 16'(doneFlag));
		$display("test refusals done");
		@(posedge clk_sys);
		ptr <= 16'h8025;
		op(7, 8'h00);
		#1;
		check("indirect stall", 16'h0001, 16'(cpuStall));
		@(posedge clk_sys);
		#1;
		check("indirect byte", 16'h0034, 16'(indirectData));
		check("indirect stall ends", 16'h0000, 16'(cpuStall));
		op(8, 8'h00);
		op(7, 8'h00);
		@(posedge clk_sys);
		#1;
		check("after indirect write", 16'h0034, 16'(indirectData));
		check("data pair held", 16'h1234, 16'(flashData));
		check("read trigger clear", 16'h0000, 16'(readTrig));
		$display("test indirect done");
		@(posedge clk_sys);
		cpBitN <= 1'b1;
		repeat (2) @(posedge clk_sys);
		#1;
		check("protect sticky", 16'h0001, 16'(codeProt));
		@(posedge clk_sys);
		bulk <= 1'b1;
		@(posedge clk_sys);
		bulk <= 1'b0;
		#1;
		check("protect removed", 16'h0000, 16'(codeProt));
		rd(15'h0025);
		check("bulk erased word", 16'h3fff, 16'(flashData));
		$display("test bulk erase done");
		op(4, 8'h05);
		op(0, 8'h02);
		op(2, 8'hcd);
		op(3, 8'h0b);
		cpu.unlock(8'haa, n);
		check("user id stall", 16'(W), 16'(n));
		rd(15'h0002);
		check("user id word", 16'h0bcd, 16'(flashData));
		op(0, 8'h05);
		op(2, 8'h00);
		op(3, 8'h00);
		cpu.unlock(8'haa, n);
		check("config word stall", 16'h0000, 16'(n));
		rd(15'h0005);
		check("config word kept", 16'h3fff, 16'(flashData));
		$display("test user id done");
		stop_test();
	end
endmodule : tb
